/* File: hw/scdpd_clock_control.v */
// Clock control: divider register, stop arming and idle/stop power states.
`timescale 1ns/100ps
`include "scdpd_defines.vh"
// Contract
// - Selection bits 4:3 choose /16, /8, /2 or /1 for codes 00, 01, 10, 11.
// - After reset the oscillator runs and the /16 setting is used.
// - The divider control register sits at D4h, is read/write and resets to zero.
// - The low three bits are meaningless and software never writes 101b to them.
// - In Stop mode the oscillator is halted and no internal clock runs.
// - Stop mode is entered only when the arming register holds A5h.
// - Stop mode ends and the oscillator restarts on reset or external interrupt.
// - Leaving Stop mode clears the arming register to zero.
// - Idle gates the CPU clock while interrupt and timer clocks keep running.
// - Idle ends on reset, external interrupt or internal interrupt.
// - The six filtered external interrupt lines are the fixed Stop wake sources.
// - The idle opcode 6Fh enters Idle mode.
// - Waking from Idle keeps the selection field and current divider.
module scdpd_clock_control #(
  parameter WAKE_LINES = 6
) (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  input wire opValid,
  input wire [7:0] opCode,
  input wire [WAKE_LINES-1:0] extWake,
  input wire intWake,
  output wire oscRun,
  output wire cpuClkEn,
  output wire periphClkEn,
  output wire inIdle,
  output wire inStop
);
  // ==========================================================================
  // Registers
  reg [7:0] clkCtl_q;
  reg [7:0] stopArm_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  wire anyExt;
  wire armed;
  wire running;
  wire tick;
  assign anyExt = |extWake;
  assign armed = (stopArm_q == `SCDPD_ARM_VALUE);
  // ==========================================================================
  // Power state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      `SCDPD_ST_RUN: begin
        if (opValid && opCode == `SCDPD_OP_IDLE) begin
          state_d = `SCDPD_ST_IDLE;
        end else if (opValid && opCode == `SCDPD_OP_STOP && armed) begin
          state_d = `SCDPD_ST_STOP;
        end
      end
      `SCDPD_ST_IDLE: begin
        if (anyExt || intWake) begin
          state_d = `SCDPD_ST_RUN;
        end
      end
      `SCDPD_ST_STOP: begin
        if (anyExt) begin
          state_d = `SCDPD_ST_RUN;
        end
      end
      default: state_d = `SCDPD_ST_RUN;
    endcase
  end
  // Only bits 4:3 reach the divider; the rest are stored for read-back only.
  always @(posedge clk_sys) begin
    if (rst) begin
      state_q <= `SCDPD_ST_RUN;
      clkCtl_q <= `SCDPD_CLKCTL_RESET;
      stopArm_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (regWrite && regAddr == `SCDPD_CLKCTL_ADDR) begin
        clkCtl_q <= regWdata;
      end
      if (state_q == `SCDPD_ST_STOP && state_d == `SCDPD_ST_RUN) begin
        stopArm_q <= 8'h00;
      end else if (regWrite && regAddr == `SCDPD_STOPARM_ADDR) begin
        stopArm_q <= regWdata;
      end
    end
  end
  // ==========================================================================
  // Read port
  always @(posedge clk_sys) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `SCDPD_CLKCTL_ADDR: regRdata <= clkCtl_q;
        `SCDPD_STOPARM_ADDR: regRdata <= stopArm_q;
        default: regRdata <= 8'h00;
      endcase
    end
  end
  // ==========================================================================
  // Clock gating
  assign inIdle = (state_q == `SCDPD_ST_IDLE);
  assign inStop = (state_q == `SCDPD_ST_STOP);
  assign oscRun = !inStop;
  assign running = oscRun;
  scdpd_divider u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(running),
    .sel(clkCtl_q[`SCDPD_SEL_MSB:`SCDPD_SEL_LSB]),
    .cpuTick(tick)
  );
  // The prescaler keeps counting in Idle so the divider phase survives the wake.
  // The tick register still holds the last pulse in the first Stop cycle, so it is masked here.
  assign cpuClkEn = tick && !inIdle && !inStop;
  assign periphClkEn = tick && !inStop;
endmodule // scdpd_clock_control

/* File: hw/scdpd_defines.vh */
// Constants for the system clock divider and power-down block.
`ifndef SCDPD_DEFINES_VH
`define SCDPD_DEFINES_VH
// ==========================================================================
// Register map
`define SCDPD_CLKCTL_ADDR 8'hd4
`define SCDPD_STOPARM_ADDR 8'hfb
`define SCDPD_CLKCTL_RESET 8'h00
`define SCDPD_SEL_MSB 4
`define SCDPD_SEL_LSB 3
`define SCDPD_ARM_VALUE 8'ha5
// ==========================================================================
// Divider selection codes
`define SCDPD_SEL_DIV16 2'b00
`define SCDPD_SEL_DIV8 2'b01
`define SCDPD_SEL_DIV2 2'b10
`define SCDPD_SEL_DIV1 2'b11
// ==========================================================================
// Opcodes
`define SCDPD_OP_IDLE 8'h6f
`define SCDPD_OP_STOP 8'h7f
// ==========================================================================
// Power states
`define SCDPD_ST_RUN 2'b00
`define SCDPD_ST_IDLE 2'b01
`define SCDPD_ST_STOP 2'b10
`endif

/* File: hw/scdpd_divider.v */
// Prescaler, halted while run is low, producing glitch-free CPU clock enables.
`timescale 1ns/100ps
`include "scdpd_defines.vh"
module scdpd_divider (
  input wire clk_sys,
  input wire rst,
  input wire run,
  input wire [1:0] sel,
  output reg cpuTick
);
  // ==========================================================================
  // Prescaler
  reg [3:0] count_q;
  reg [1:0] selAct_q;
  wire wrap;
  reg hit;
  assign wrap = (count_q == 4'hf);
  always @* begin
    case (selAct_q)
      `SCDPD_SEL_DIV16: hit = wrap;
      `SCDPD_SEL_DIV8: hit = (count_q[2:0] == 3'h7);
      `SCDPD_SEL_DIV2: hit = count_q[0];
      `SCDPD_SEL_DIV1: hit = 1'b1;
      default: hit = wrap;
    endcase
  end
  // A new selection is only adopted at the end of a full /16 period, so no
  // enable period is ever cut short by a change in the middle of it.
  always @(posedge clk_sys) begin
    if (rst) begin
      count_q <= 4'h0;
      selAct_q <= `SCDPD_SEL_DIV16;
      cpuTick <= 1'b0;
    end else if (!run) begin
      cpuTick <= 1'b0;
    end else begin
      count_q <= count_q + 4'h1;
      cpuTick <= hit;
      if (wrap) begin
        selAct_q <= sel;
      end
    end
  end
endmodule // scdpd_divider

/* File: test/scdpd_assertions.sv */
// Port checker for the clock control block.
`timescale 1ns/100ps
module scdpd_assertions #(parameter WAKE_LINES = 6) (
  input wire clk_sys, input wire rst, input wire opValid, input wire [7:0] opCode,
  input wire [WAKE_LINES-1:0] extWake, input wire intWake, input wire oscRun,
  input wire cpuClkEn, input wire periphClkEn, input wire inIdle, input wire inStop);
  // ====================
  // Power state checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire wake = |extWake || intWake;
  wire stopOp = opValid && opCode == 8'h7f;
  wire idleOp = opValid && opCode == 8'h6f && !inIdle && !inStop && !wake;
  AST_OSC: assert property (oscRun == !inStop) else $error("osc state");
  AST_STOPCLK: assert property (inStop |-> !cpuClkEn && !periphClkEn)
    else $error("clock in stop");
  AST_IDLECPU: assert property (inIdle |-> !cpuClkEn) else $error("cpu tick in idle");
  AST_IDLEPER: assert property (inIdle |-> ##[0:16] (periphClkEn || !inIdle))
    else $error("no periph tick");
  AST_IDLEIN: assert property (idleOp |=> inIdle) else $error("idle entry");
  AST_STOPIN: assert property ($rose(inStop) |-> $past(stopOp))
    else $error("stop entry");
  AST_STOPOUT: assert property (inStop && |extWake |=> !inStop && oscRun)
    else $error("stop exit");
  AST_IDLEOUT: assert property (inIdle && wake |=> !inIdle) else $error("idle exit");
  cover property ($rose(inIdle));
  cover property ($rose(inStop));
  cover property ($fell(inStop));
endmodule // scdpd_assertions
bind scdpd_clock_control scdpd_assertions #(.WAKE_LINES(WAKE_LINES)) u_scdpd_assertions (
  .clk_sys(clk_sys), .rst(rst), .opValid(opValid), .opCode(opCode), .extWake(extWake),
  .intWake(intWake), .oscRun(oscRun), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
  .inIdle(inIdle), .inStop(inStop));

/* File: test/test_scdpd_clock_control.sv */
// Self-checking bench for the clock control block.
`timescale 1ns/100ps
module test_scdpd_clock_control;
  reg clk_sys = 0, rst = 1, regWrite = 0, regRead = 0, opValid = 0, intWake = 0;
  reg [7:0] regAddr = 0, regWdata = 0, opCode = 0;
  reg [5:0] extWake = 0;
  wire [7:0] regRdata;
  wire oscRun, cpuClkEn, periphClkEn, inIdle, inStop;
  integer n_errors = 0, checked = 0, cyc = 0, i, n, m;
  always #2 clk_sys = ~clk_sys;
  scdpd_clock_control u_scdpd_clock_control (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .opValid(opValid), .opCode(opCode), .extWake(extWake), .intWake(intWake), .oscRun(oscRun),
    .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .inIdle(inIdle), .inStop(inStop));
  // ====================
  // Shared tasks
  task ck(input [7:0] got, input [7:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWdata = d;
    regWrite = 1;
    @(negedge clk_sys);
    regWrite = 0;
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    @(negedge clk_sys);
    regAddr = a;
    regRead = 1;
    @(negedge clk_sys);
    regRead = 0;
    ck(regRdata, exp);
  endtask
  task op(input [7:0] c);
    @(negedge clk_sys);
    opCode = c;
    opValid = 1;
    @(negedge clk_sys);
    opValid = 0;
  endtask
  // Measures the spacing of CPU ticks; bounded so a dead divider cannot hang the run.
  task per(input [7:0] exp);
    n = 0;
    while (cpuClkEn !== 1 && n < 40) begin
      @(negedge clk_sys);
      n = n + 1;
    end
    n = 0;
    do begin
      @(negedge clk_sys);
      n = n + 1;
    end while (cpuClkEn !== 1 && n < 40);
    ck(n, exp);
  endtask
  // ====================
  // Scenarios
  task t_div;
    rd(8'hd4, 8'h00);
    per(8'h10);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'hd4, {3'h0, i[1:0], 3'h0});
      rd(8'hd4, {3'h0, i[1:0], 3'h0});
      repeat (20) @(negedge clk_sys);
      per(i == 0 ? 8'h10 : i == 1 ? 8'h08 : i == 2 ? 8'h02 : 8'h01);
    end
    rd(8'h10, 8'h00);
    $display("divider test done");
  endtask
  task t_idle;
    op(8'h6f);
    ck(inIdle, 8'h01);
    n = 0;
    m = 0;
    repeat (32) begin
      @(negedge clk_sys);
      n = n + (cpuClkEn !== 0);
      m = m + (periphClkEn === 1);
    end
    ck(n, 8'h00);
    ck(m, 8'h20);
    intWake = 1;
    @(negedge clk_sys);
    intWake = 0;
    ck(inIdle, 8'h00);
    rd(8'hd4, 8'h18);
    per(8'h01);
    $display("idle test done");
  endtask
  task t_stop;
    op(8'h7f);
    ck(inStop, 8'h00);
    wr(8'hfb, 8'ha5);
    op(8'h7f);
    ck({inStop, oscRun}, 8'h02);
    intWake = 1;
    repeat (3) @(negedge clk_sys);
    ck({inStop, cpuClkEn, periphClkEn}, 8'h04);
    intWake = 0;
    extWake = 6'h20;
    @(negedge clk_sys);
    extWake = 0;
    ck({inStop, oscRun}, 8'h01);
    rd(8'hfb, 8'h00);
    wr(8'hfb, 8'ha5);
    op(8'h7f);
    rst = 1;
    repeat (2) @(negedge clk_sys);
    rst = 0;
    ck({inStop, oscRun}, 8'h01);
    rd(8'hfb, 8'h00);
    rd(8'hd4, 8'h00);
    $display("stop test done");
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 0;
    t_div;
    t_idle;
    t_stop;
    wrap_up;
  end
endmodule // test_scdpd_clock_control
